// ==== src/mcs_regs.sv ====
// misc register set: checksum, soft irq, flags, scratch, part number
//
// Summary of operation
// - checksum uses generator x^8+x^2+x+1 as in smbus packet checking.
// - checksum data and result registers sit in register module 1.
// - every byte written to the data-in register feeds the checksum.
// - result register holds checksum of bytes since it was last written with a seed, readable.
// - four software interrupt sources exist for application use.
// - writing one to trigger bits 3:0 raises that interrupt request.
// - bits 7:4 are plain flags, single cycle, no side effect.
// - sixteen 16-bit scratch words in module 3, read/write, reset zero.
// - scratch words one and two read in one cycle, write in two.
// - scratch words three to sixteen read and write in two cycles.
// - lock bit 7 set stops the slave port answering address 34h.
// - power-on reset clears the loader address disable bit.
// - power-on reset loads the part number register default.
// - bits 6:0 hold a readable production part number.
`timescale 1ns/1ps
module mcs_regs
  import mcs_pkg::*;
#(
  // production value, arbitrary default
  parameter logic [PART_NUM_W-1:0] PART_NUM_DEFAULT = 7'h2A
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // register bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [DAT_W-1:0] i_wb_dat,
  input wire logic [SEL_W-1:0] i_wb_sel,
  // serial slave port query
  input wire logic [SLV_ADR_W-1:0] i_slv_addr,
  input wire logic i_slv_addr_vld,
  output logic [DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  // interrupts and loader lock
  output logic [SOFT_IRQ_W-1:0] o_soft_irq,
  output logic o_irq,
  output logic o_loader_address_disable,
  output logic o_loader_addr_match
);

  // address decode helpers, shared by timing and data paths
  function automatic logic is_scratch(input logic [ADR_W-1:0] a);
    return a[ADR_W-1:SCR_SPAN_LSB] == OFS_SCR_BASE[ADR_W-1:SCR_SPAN_LSB];
  endfunction

  function automatic logic [SCR_IDX_W-1:0] scr_index(
    input logic [ADR_W-1:0] a);
    return a[SCR_IDX_LSB +: SCR_IDX_W];
  endfunction

  // byte-lane merge for 16-bit storage
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = nw[7:0];
    end
    if (sel[1]) begin
      r[15:8] = nw[15:8];
    end
    return r;
  endfunction

  // lane 0 write to one byte register; shared by every byte register
  function automatic logic byte_hit(input logic stb,
                                    input logic lane,
                                    input logic [ADR_W-1:0] a,
                                    input logic [ADR_W-1:0] ofs);
    return stb && lane && (a == ofs);
  endfunction

  // scratch words one and two read without a wait state
  function automatic logic is_fast_scr(input logic [ADR_W-1:0] a);
    return is_scratch(a) && (scr_index(a) <= SCR_FAST_LAST);
  endfunction

  // bus state
  mcs_bus_e state_q;
  logic ack_q;
  logic [DAT_W-1:0] rdat_q;
  logic [DAT_W-1:0] rd_mux;
  logic req;
  logic slow;
  logic wr_stb;
  logic lane0;
  logic rd_take;

  // register state
  logic [SOFT_IRQ_W-1:0] soft_irq_q;
  logic [SOFT_FLAG_W-1:0] soft_flag_q;
  logic [SOFT_IRQ_W-1:0] irq_stat_q;
  logic [SOFT_IRQ_W-1:0] irq_mask_q;
  logic [SOFT_IRQ_W-1:0] irq_set;
  logic [SOFT_IRQ_W-1:0] irq_clr;
  logic irq_q;
  logic loader_address_disable_q;
  logic [PART_NUM_W-1:0] part_num_q;
  logic [7:0] crc_in_q;
  logic [15:0] scratch_q [SCR_NUM];
  logic match_q;
  logic loader_hit;
  logic [SOFT_IRQ_W-1:0] irq_pend;

  // per-register write strobes
  logic wr_soft;
  logic wr_part;
  logic wr_stat;
  logic wr_mask;
  logic wr_crc_in;
  logic wr_crc_res;
  logic wr_scr;

  // carrier to the checksum engine
  mcs_crc_if crc_bus ();

  // request qualifiers
  assign req = i_wb_cyc & i_wb_stb;
  assign lane0 = i_wb_sel[0];

  // fast scratch reads skip the wait state, other scratch access waits
  assign slow = is_scratch(i_wb_adr) &&
                (i_wb_we || !is_fast_scr(i_wb_adr));

  // a write lands on the edge where the master sees ack high
  assign wr_stb = ack_q & req & i_wb_we;

  // write strobes; a byte register needs lane 0
  assign wr_soft = byte_hit(wr_stb, lane0, i_wb_adr, OFS_SOFT);
  assign wr_part = byte_hit(wr_stb, lane0, i_wb_adr, OFS_PART);
  assign wr_stat = byte_hit(wr_stb, lane0, i_wb_adr, OFS_IRQ_STAT);
  assign wr_mask = byte_hit(wr_stb, lane0, i_wb_adr, OFS_IRQ_MASK);
  assign wr_crc_in = byte_hit(wr_stb, lane0, i_wb_adr, OFS_CRC_IN);
  assign wr_crc_res = byte_hit(wr_stb, lane0, i_wb_adr, OFS_CRC_RES);
  assign wr_scr = wr_stb && is_scratch(i_wb_adr);

  // read data is taken once, in the cycle before ack rises
  assign rd_take = req && !i_wb_we && !ack_q &&
                   (state_q == BUS_WAIT || (state_q == BUS_IDLE && !slow));

  // bus sequencer: idle -> (wait) -> ack -> idle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= BUS_IDLE;
      ack_q <= 1'b0;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          ack_q <= 1'b0;
          if (req && slow) begin
            state_q <= BUS_WAIT;
          end else if (req) begin
            state_q <= BUS_ACK;
            ack_q <= 1'b1;
          end
        end
        BUS_WAIT: begin
          // master may abandon a cycle; then no ack
          if (req) begin
            state_q <= BUS_ACK;
            ack_q <= 1'b1;
          end else begin
            state_q <= BUS_IDLE;
          end
        end
        BUS_ACK: begin
          state_q <= BUS_IDLE;
          ack_q <= 1'b0;
        end
        default: begin
          state_q <= BUS_IDLE;
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // read data captured as ack rises, zero for unmapped addresses
  always_comb begin
    rd_mux = BUS_ZERO;
    if (is_scratch(i_wb_adr)) begin
      rd_mux[15:0] = scratch_q[scr_index(i_wb_adr)];
    end else begin
      case (i_wb_adr)
        OFS_SOFT: begin
          rd_mux[SOFT_FLAG_LSB +: SOFT_FLAG_W] = soft_flag_q;
          rd_mux[SOFT_IRQ_LSB +: SOFT_IRQ_W] = soft_irq_q;
        end
        OFS_PART: begin
          rd_mux[LOADER_ADDRESS_DISABLE_BIT] = loader_address_disable_q;
          rd_mux[PART_NUM_W-1:0] = part_num_q;
        end
        OFS_IRQ_STAT: rd_mux[SOFT_IRQ_W-1:0] = irq_stat_q;
        OFS_IRQ_MASK: rd_mux[SOFT_IRQ_W-1:0] = irq_mask_q;
        OFS_CRC_IN: rd_mux[7:0] = crc_in_q;
        OFS_CRC_RES: rd_mux[7:0] = crc_bus.crc;
        default: rd_mux = BUS_ZERO;
      endcase
    end
  end

  // held until the next read, so a late look still sees the word
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdat_q <= BUS_ZERO;
    end else if (rd_take) begin
      rdat_q <= rd_mux;
    end
  end

  // soft trigger bits; level, stay until software writes zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      soft_irq_q <= IRQ_ZERO;
    end else if (wr_soft) begin
      soft_irq_q <= i_wb_dat[SOFT_IRQ_LSB +: SOFT_IRQ_W];
    end
  end

  // flags are pure storage with no side effect
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      soft_flag_q <= IRQ_ZERO;
    end else if (wr_soft) begin
      soft_flag_q <= i_wb_dat[SOFT_FLAG_LSB +: SOFT_FLAG_W];
    end
  end

  // each one written to a trigger bit is an event, even if already set
  assign irq_set = wr_soft ?
                   i_wb_dat[SOFT_IRQ_LSB +: SOFT_IRQ_W] : IRQ_ZERO;
  assign irq_clr = wr_stat ?
                   i_wb_dat[SOFT_IRQ_W-1:0] : IRQ_ZERO;

  // sticky status, write one to clear; a set beats a clear
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat_q <= IRQ_ZERO;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // mask has the status layout
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_mask_q <= IRQ_ZERO;
    end else if (wr_mask) begin
      irq_mask_q <= i_wb_dat[SOFT_IRQ_W-1:0];
    end
  end

  // pending sources; the level output costs a cycle to stay flopped
  assign irq_pend = irq_stat_q & irq_mask_q;

  // level interrupt, one cycle behind status for a flopped output
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |irq_pend;
    end
  end

  // loader lock, clear after power-up so the loader is reachable until software sets the lock
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      loader_address_disable_q <= LOADER_ADDRESS_DISABLE_RST;
    end else if (wr_part) begin
      loader_address_disable_q <= i_wb_dat[LOADER_ADDRESS_DISABLE_BIT];
    end
  end

  // part number; rewritable by software, default restored by reset
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      part_num_q <= PART_NUM_DEFAULT;
    end else if (wr_part) begin
      part_num_q <= i_wb_dat[PART_NUM_W-1:0];
    end
  end

  // a qualified query for the loader address
  assign loader_hit = i_slv_addr_vld && (i_slv_addr == LOADER_ADDR);

  // slave port asks whether it may claim an address it decoded
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= loader_hit && !loader_address_disable_q;
    end
  end

  // last byte fed, kept for readback
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      crc_in_q <= BYTE_ZERO;
    end else if (crc_bus.feed) begin
      crc_in_q <= i_wb_dat[7:0];
    end
  end

  // engine hookup in module 1; one feed per accepted write
  assign crc_bus.feed = wr_crc_in;
  assign crc_bus.byte_in = i_wb_dat[7:0];
  assign crc_bus.load = wr_crc_res;
  assign crc_bus.load_val = i_wb_dat[7:0];

  mcs_crc8 u_crc (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .crc_bus(crc_bus)
  );

  // scratch storage; no side effects, lanes honoured
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < SCR_NUM; i++) begin
        scratch_q[i] <= WORD_ZERO;
      end
    end else if (wr_scr) begin
      scratch_q[scr_index(i_wb_adr)] <=
        merge16(scratch_q[scr_index(i_wb_adr)], i_wb_dat[15:0],
                i_wb_sel[1:0]);
    end
  end

  // outputs, all from flops
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_soft_irq = soft_irq_q;
  assign o_irq = irq_q;
  assign o_loader_address_disable = loader_address_disable_q;
  assign o_loader_addr_match = match_q;

endmodule

// ==== src/mcs_pkg.sv ====
// shared constants and types for the misc crc / soft irq / scratch block
package mcs_pkg;

  // wishbone geometry
  localparam int unsigned ADR_W = 12;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;

  // register module 0: soft irq, part number, irq status and mask
  localparam logic [ADR_W-1:0] OFS_SOFT = 12'h000;
  localparam logic [ADR_W-1:0] OFS_PART = 12'h004;
  localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 12'h00C;
  // register module 1: checksum engine
  localparam logic [ADR_W-1:0] OFS_CRC_IN = 12'h100;
  localparam logic [ADR_W-1:0] OFS_CRC_RES = 12'h104;
  // register module 3: scratch words, one aligned word each
  localparam logic [ADR_W-1:0] OFS_SCR_BASE = 12'h300;
  localparam int unsigned SCR_SPAN_LSB = 6;
  localparam int unsigned SCR_IDX_LSB = 2;
  localparam int unsigned SCR_IDX_W = 4;
  localparam int unsigned SCR_NUM = 16;
  localparam logic [SCR_IDX_W-1:0] SCR_FAST_LAST = 4'h1;

  // field layout
  localparam int unsigned SOFT_IRQ_LSB = 0;
  localparam int unsigned SOFT_IRQ_W = 4;
  localparam int unsigned SOFT_FLAG_LSB = 4;
  localparam int unsigned SOFT_FLAG_W = 4;
  localparam int unsigned LOADER_ADDRESS_DISABLE_BIT = 7;
  localparam int unsigned PART_NUM_W = 7;
  localparam int unsigned SLV_ADR_W = 7;

  // reset values and constants
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [DAT_W-1:0] BUS_ZERO = 32'h0000_0000;
  localparam logic [SOFT_IRQ_W-1:0] IRQ_ZERO = 4'h0;
  localparam logic LOADER_ADDRESS_DISABLE_RST = 1'b0;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [SLV_ADR_W-1:0] LOADER_ADDR = 7'h34;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WAIT,
    BUS_ACK
  } mcs_bus_e;

endpackage

// ==== src/mcs_crc_if.sv ====
// carrier between the register file and the checksum engine
`timescale 1ns/1ps
interface mcs_crc_if;
  logic feed;
  logic [7:0] byte_in;
  logic load;
  logic [7:0] load_val;
  logic [7:0] crc;

  modport engine (
    input feed,
    input byte_in,
    input load,
    input load_val,
    output crc
  );
  modport regs (
    output feed,
    output byte_in,
    output load,
    output load_val,
    input crc
  );
endinterface

// ==== src/mcs_crc8.sv ====
// smbus-style crc-8 engine, one byte per clock
`timescale 1ns/1ps
module mcs_crc8
  import mcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  mcs_crc_if.engine crc_bus
);

  logic [7:0] crc_q;

  // msb first, no reflection, no final xor
  function automatic logic [7:0] crc8_byte(input logic [7:0] c,
                                           input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // whole byte folded in one cycle so back-to-back writes are safe
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      crc_q <= CRC_INIT;
    end else if (crc_bus.load) begin
      crc_q <= crc_bus.load_val;
    end else if (crc_bus.feed) begin
      crc_q <= crc8_byte(crc_q, crc_bus.byte_in);
    end
  end

  assign crc_bus.crc = crc_q;

endmodule

// ==== testbench/mcs_regs_assertions.sv ====
// port-level checks for the misc register block
`timescale 1ns/1ps
module mcs_regs_assertions
  import mcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [DAT_W-1:0] i_wb_dat,
  input wire logic [SEL_W-1:0] i_wb_sel,
  input wire logic [SLV_ADR_W-1:0] i_slv_addr,
  input wire logic i_slv_addr_vld,
  input wire logic [DAT_W-1:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [SOFT_IRQ_W-1:0] o_soft_irq,
  input wire logic o_irq,
  input wire logic o_loader_address_disable,
  input wire logic o_loader_addr_match
);
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  logic req_q;
  logic req_new;
  logic scr;
  // first cycle of a request, so latencies count from the take
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= i_wb_cyc && i_wb_stb;
    end
  end
  assign req_new = i_wb_cyc && i_wb_stb && !o_wb_ack && !req_q;
  assign scr = i_wb_adr[11:6] == 6'h0C;
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_fast_scr_rd: assert property (req_new && !i_wb_we && scr &&
    i_wb_adr[5:2] <= SCR_FAST_LAST |=> o_wb_ack)
    else $error("fast scratch read late");
  a_slow_scr_rd: assert property (req_new && !i_wb_we && scr &&
    i_wb_adr[5:2] > SCR_FAST_LAST |=> !o_wb_ack ##1 o_wb_ack)
    else $error("slow scratch read timing");
  a_slow_scr_wr: assert property (req_new && i_wb_we && scr
    |=> !o_wb_ack ##1 o_wb_ack)
    else $error("scratch write timing");
  a_flag_single: assert property (req_new &&
    i_wb_adr == OFS_SOFT |=> o_wb_ack)
    else $error("flag access not single cycle");
  a_trig_raise: assert property (o_wb_ack && i_wb_we &&
    i_wb_adr == OFS_SOFT && i_wb_sel[0]
    |=> o_soft_irq == $past(i_wb_dat[3:0]))
    else $error("trigger bits not written");
  a_lock_write: assert property (o_wb_ack && i_wb_we &&
    i_wb_adr == OFS_PART && i_wb_sel[0]
    |=> o_loader_address_disable == $past(i_wb_dat[7]))
    else $error("lock bit not written");
  a_loader_match: assert property (i_slv_addr_vld &&
    i_slv_addr == LOADER_ADDR && !o_loader_address_disable
    |=> o_loader_addr_match)
    else $error("loader address not matched");
  a_loader_block: assert property (o_loader_address_disable
    |=> !o_loader_addr_match)
    else $error("loader address answered while locked");
  a_no_req_ack: assert property (!(i_wb_cyc && i_wb_stb)
    |=> !o_wb_ack)
    else $error("ack without request");
endmodule

bind mcs_regs mcs_regs_assertions u_mcs_regs_assertions (
  .i_clk_sys, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .i_wb_dat, .i_wb_sel, .i_slv_addr, .i_slv_addr_vld, .o_wb_dat,
  .o_wb_ack, .o_soft_irq, .o_irq, .o_loader_address_disable,
  .o_loader_addr_match
);

// ==== testbench/tb_top.sv ====
// self-checking bench for the misc register block
`timescale 1ns/1ps
module tb_top;
  import mcs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [SLV_ADR_W-1:0] saddr = '0;
  logic svld = 1'b0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic [SOFT_IRQ_W-1:0] soft_irq;
  logic irq;
  logic dis;
  logic match;
  logic [31:0] rd;
  logic [7:0] crc_e;
  int num_errors = 0;
  int n_checks = 0;

  mcs_regs u_mcs_regs (
    .i_clk_sys(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .i_slv_addr(saddr), .i_slv_addr_vld(svld), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_soft_irq(soft_irq), .o_irq(irq),
    .o_loader_address_disable(dis), .o_loader_addr_match(match)
  );

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; waits for ack, the watchdog guards a dead slave
  task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [ADR_W-1:0] a,
                     input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask

  task automatic slv(input logic [6:0] a, input logic exp);
    @(posedge clk);
    svld <= 1'b1;
    saddr <= a;
    repeat (2) @(posedge clk);
    check("match", 32'(match), 32'(exp));
    svld <= 1'b0;
  endtask

  // msb-first reference step, no reflection or final inversion
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc("part", OFS_PART, 32'h2A);
    check("lock", 32'(dis), 32'h0);
    for (int i = 0; i < 16; i++) begin
      rdc("scr_rst", OFS_SCR_BASE + 12'(i * 4), 32'h0);
      wb(1'b1, OFS_SCR_BASE + 12'(i * 4), 32'hFFFF_C3C0 + i);
    end
    for (int i = 0; i < 16; i++) begin
      rdc("scr", OFS_SCR_BASE + 12'(i * 4), 32'hC3C0 + i);
    end
    wb(1'b1, 12'h200, 32'hFF);
    rdc("unmapped", 12'h200, 32'h0);
    // checksum over nine bytes written one bus cycle apart from a zero start
    wb(1'b1, OFS_CRC_RES, 32'h0);
    crc_e = 8'h00;
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, OFS_CRC_IN, 32'h31 + i);
      crc_e = crc_step(crc_e, 8'h31 + 8'(i));
    end
    rdc("crc", OFS_CRC_RES, 32'(crc_e));
    wb(1'b1, OFS_CRC_RES, 32'h5C);
    wb(1'b1, OFS_CRC_IN, 32'hE7);
    rdc("crc_seed", OFS_CRC_RES, 32'(crc_step(8'h5C, 8'hE7)));
    rdc("crc_in", OFS_CRC_IN, 32'hE7);
    // soft interrupts: masked, unmasked, cleared
    wb(1'b1, OFS_IRQ_MASK, 32'h2);
    wb(1'b1, OFS_SOFT, 32'hA5);
    rdc("soft", OFS_SOFT, 32'hA5);
    check("trig", 32'(soft_irq), 32'h5);
    rdc("stat", OFS_IRQ_STAT, 32'h5);
    check("irq_masked", 32'(irq), 32'h0);
    wb(1'b1, OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    check("irq", 32'(irq), 32'h1);
    wb(1'b1, OFS_IRQ_STAT, 32'h5);
    repeat (2) @(posedge clk);
    check("irq_clr", 32'(irq), 32'h0);
    // loader address before and after the lock
    slv(7'h34, 1'b1);
    slv(7'h35, 1'b0);
    wb(1'b1, OFS_PART, 32'h80);
    @(posedge clk);
    check("lock_set", 32'(dis), 32'h1);
    slv(7'h34, 1'b0);
    rdc("part_lock", OFS_PART, 32'h80);
    test_done();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule
